/* pkg/exc_pkg.sv */
package exc_pkg;

   // ---------------------------------------------------------------
   // source ranking: lower index wins
   // ---------------------------------------------------------------
   localparam int N_SRC = 7;

   typedef enum logic [2:0] {
      SRC_RESET  = 3'h0,
      SRC_NMI    = 3'h1,
      SRC_SYS_ERR = 3'h2,
      SRC_INT    = 3'h3,
      SRC_EXECP  = 3'h4,
      SRC_DATAP  = 3'h5,
      SRC_FERR   = 3'h6
   } src_type;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_FERR = 1'b1
   } state_type;

   // ---------------------------------------------------------------
   // priority groups
   // ---------------------------------------------------------------
   localparam logic [2:0] GRP_P1  = 3'h1;
   localparam logic [2:0] GRP_P2  = 3'h2;
   localparam logic [2:0] GRP_P3  = 3'h3;
   localparam logic [2:0] GRP_P4  = 3'h4;
   localparam logic [2:0] GRP_P5  = 3'h5;
   localparam logic [2:0] GRP_P7  = 3'h7;
   localparam logic [2:0] GRP_FERR = GRP_P7;

   // ---------------------------------------------------------------
   // cause codes and handler offsets
   // ---------------------------------------------------------------
   localparam logic [31:0] CODE_FERR    = 32'h0000_0330;
   localparam logic [15:0] OFFS_FERR    = 16'h0030;
   localparam logic [15:0] OFFS_SYS_ERR = 16'h0030;
   localparam logic [31:0] CODE_RESET  = 32'h0000_0000;
   localparam logic [15:0] OFFS_RESET  = 16'h0000;
   localparam logic [31:0] CODE_NMI    = 32'h0000_00E0;
   localparam logic [15:0] OFFS_NMI    = 16'h00E0;
   localparam logic [31:0] CODE_EXECP  = 32'h0000_0430;
   localparam logic [15:0] OFFS_EXECP  = 16'h0040;
   localparam logic [31:0] CODE_DATAP  = 32'h0000_0431;
   localparam logic [15:0] OFFS_DATAP  = 16'h0040;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_OFFS = 16'h0000;
   localparam logic [2:0]  RST_GRP  = 3'h0;

endpackage : exc_pkg

/* pkg/fetch_if.sv */
interface fetch_if;
   logic        ferr_event;
   logic        ded_flash;
   logic        single_fix;
   logic [31:0] pc;

   modport chk (output ferr_event, output ded_flash, output single_fix, output pc);
   modport arb (input ferr_event, input ded_flash, input single_fix, input pc);
endinterface : fetch_if

/* hdl/pend_latch.sv */
module pend_latch (
   input  wire logic clock_i,
   input  wire logic resetn_i,
   input  wire logic set_i,
   input  wire logic clear_i,
   output logic      pend_o
);

   // set beats clear so an event in the serving cycle survives
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pend_o <= 1'b0;
      end else if (set_i) begin
         pend_o <= 1'b1;
      end else if (clear_i) begin
         pend_o <= 1'b0;
      end
   end

   pend_set_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      set_i |=> pend_o)
      else $error("pending bit lost its set");

endmodule : pend_latch

/* hdl/fetch_check.sv */
module fetch_check (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        fetch_valid_i,
   input  wire logic        fetch_undef_i,
   input  wire logic        fetch_ded_i,
   input  wire logic        fetch_sec_i,
   input  wire logic        fetch_flash_i,
   input  wire logic [31:0] fetch_pc_i,
   fetch_if.chk             chk
);

   // any code read counts, preloads included, executed or not
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chk.ferr_event <= 1'b0;
         chk.ded_flash  <= 1'b0;
         chk.single_fix <= 1'b0;
      end else begin
         chk.ferr_event <= fetch_valid_i & (fetch_undef_i | fetch_ded_i);
         chk.ded_flash  <= fetch_valid_i & fetch_ded_i & fetch_flash_i & ~fetch_undef_i;
         chk.single_fix <= fetch_valid_i & fetch_sec_i & ~fetch_ded_i & ~fetch_undef_i;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         chk.pc <= 32'h0000_0000;
      end else if (fetch_valid_i) begin
         chk.pc <= fetch_pc_i;
      end
   end

   single_fix_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      fetch_valid_i && fetch_sec_i && !fetch_ded_i && !fetch_undef_i |=> !chk.ferr_event && chk.single_fix)
      else $error("corrected fetch raised an error");

endmodule : fetch_check

/* hdl/exc_arbiter.sv */
// Contract
// - reset P1, high nmi P2, system error P3
// - interrupt P4, exec P5, data protect P7
// - serve pending requests P1 first, P7 last
// - requests stay pending until served
// - acknowledge suspends flow, branches to handler
// - check acceptance unless unconditional type
// - fetch error taken with no conditions
// - fetch error cause code 0330 hex
// - fetch error handler offset 0030 hex
// - fetch error sits in group P7
// - fetch error has no mask
// - any code read raises it, preloads too
// - flash ded, ram ded, undefined area
// - ram/undefined cause only in saved pc
// - single errors corrected, no exception
// - fetch error in handler restarts it
// - nmi and system error accepted during handler
// - flash double error sets status flag
module exc_arbiter
   import exc_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        reset_req_i,
   input  wire logic        fe_nonmaskable_irq_i,
   input  wire logic        system_error_exc_i,
   input  wire logic [31:0] sys_err_code_i,
   input  wire logic        int_req_i,
   input  wire logic [31:0] int_code_i,
   input  wire logic [15:0] int_offset_i,
   input  wire logic        exec_protect_exc_i,
   input  wire logic        data_protect_exc_i,
   input  wire logic        fetch_valid_i,
   input  wire logic        fetch_undef_i,
   input  wire logic        fetch_ded_i,
   input  wire logic        fetch_sec_i,
   input  wire logic        fetch_flash_i,
   input  wire logic [31:0] fetch_pc_i,
   input  wire logic        flash_data_ded_i,
   input  wire logic        ded_clear_i,
   input  wire logic [31:0] core_pc_i,
   input  wire logic        lo_accept_i,
   input  wire logic        hi_accept_i,
   input  wire logic        handler_exit_i,
   output logic             exc_take_o,
   output logic [31:0]      exc_code_o,
   output logic [15:0]      exc_offset_o,
   output logic [2:0]       exc_group_o,
   output logic [31:0]      high_level_cause_reg_o,
   output logic [31:0]      high_level_pc_save_o,
   output logic             double_error_flag_o,
   output logic             ferr_busy_o,
   output logic             fetch_fixed_o
);

   localparam logic [N_SRC-1:0] ONE = {{(N_SRC-1){1'b0}}, 1'b1};

   fetch_if fif ();

   logic [N_SRC-1:0] raw_set;
   logic [N_SRC-1:0] pend;
   logic [N_SRC-1:0] cond;
   logic [N_SRC-1:0] eligible;
   logic [N_SRC-1:0] grant_clr;
   logic [N_SRC-1:0] win_hot;
   logic [2:0]       win_idx;
   logic             take_go;
   logic             hi_elig;
   logic             take_r;
   state_type        state_r;
   state_type        state_nxt;
   logic [31:0]      ferr_pc_r;
   logic [31:0]      sel_code;
   logic [15:0]      sel_offs;
   logic [2:0]       sel_grp;
   logic             sel_hi;
   logic [31:0]      sel_pc;
   logic             ded_flag_r;

   // ---------------------------------------------------------------
   // fetch error detection
   // ---------------------------------------------------------------
   fetch_check u_fetch_check (
      .clock_i       (clock_i),
      .resetn_i      (resetn_i),
      .fetch_valid_i (fetch_valid_i),
      .fetch_undef_i (fetch_undef_i),
      .fetch_ded_i   (fetch_ded_i),
      .fetch_sec_i   (fetch_sec_i),
      .fetch_flash_i (fetch_flash_i),
      .fetch_pc_i    (fetch_pc_i),
      .chk           (fif.chk)
   );

   // ---------------------------------------------------------------
   // pending requests
   // ---------------------------------------------------------------
   always_comb begin
      raw_set             = '0;
      raw_set[SRC_RESET]  = reset_req_i;
      raw_set[SRC_NMI]    = fe_nonmaskable_irq_i;
      raw_set[SRC_SYS_ERR] = system_error_exc_i;
      raw_set[SRC_INT]    = int_req_i;
      raw_set[SRC_EXECP]  = exec_protect_exc_i;
      raw_set[SRC_DATAP]  = data_protect_exc_i;
      raw_set[SRC_FERR]   = fif.ferr_event;
   end

   for (genvar g = 0; g < N_SRC; g++) begin : g_pend
      pend_latch u_pend (
         .clock_i  (clock_i),
         .resetn_i (resetn_i),
         .set_i    (raw_set[g]),
         .clear_i  (grant_clr[g]),
         .pend_o   (pend[g])
      );
   end

   // pc of the latest failing code read; the only hint for ram/undefined
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ferr_pc_r <= RST_WORD;
      end else if (fif.ferr_event) begin
         ferr_pc_r <= fif.pc;
      end
   end

   // ---------------------------------------------------------------
   // acceptance and arbitration
   // ---------------------------------------------------------------
   always_comb begin
      cond             = '0;
      cond[SRC_RESET]  = 1'b1;
      cond[SRC_NMI]    = 1'b1;
      cond[SRC_SYS_ERR] = 1'b1;
      cond[SRC_INT]    = lo_accept_i;
      cond[SRC_EXECP]  = hi_accept_i & (state_r == ST_RUN);
      cond[SRC_DATAP]  = hi_accept_i & (state_r == ST_RUN);
      cond[SRC_FERR]   = 1'b1;
   end

   assign eligible = pend & cond;

   // lowest index wins, so the scan runs from the top index down and the last hit sticks
   always_comb begin
      win_idx = 3'h0;
      for (int i = N_SRC - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            win_idx = 3'(i);
         end
      end
   end

   // one-cycle gap after each take lets the core see the branch first
   assign take_go   = (|eligible) & ~take_r;
   assign win_hot   = ONE << win_idx;
   assign grant_clr = take_go ? win_hot : '0;
   assign hi_elig   = ((eligible & (~eligible + ONE)) != win_hot);

   always_comb begin
      sel_code = CODE_RESET;
      sel_offs = OFFS_RESET;
      sel_grp  = GRP_P1;
      sel_hi   = 1'b0;
      sel_pc   = core_pc_i;
      case (win_idx)
         SRC_RESET: begin
            sel_grp = GRP_P1;
         end
         SRC_NMI: begin
            sel_code = CODE_NMI;
            sel_offs = OFFS_NMI;
            sel_grp  = GRP_P2;
            sel_hi   = 1'b1;
         end
         SRC_SYS_ERR: begin
            sel_code = sys_err_code_i;
            sel_offs = OFFS_SYS_ERR;
            sel_grp  = GRP_P3;
            sel_hi   = 1'b1;
         end
         SRC_INT: begin
            sel_code = int_code_i;
            sel_offs = int_offset_i;
            sel_grp  = GRP_P4;
         end
         SRC_EXECP: begin
            sel_code = CODE_EXECP;
            sel_offs = OFFS_EXECP;
            sel_grp  = GRP_P5;
            sel_hi   = 1'b1;
         end
         SRC_DATAP: begin
            sel_code = CODE_DATAP;
            sel_offs = OFFS_DATAP;
            sel_grp  = GRP_P7;
            sel_hi   = 1'b1;
         end
         SRC_FERR: begin
            sel_code = CODE_FERR;
            sel_offs = OFFS_FERR;
            sel_grp  = GRP_FERR;
            sel_hi   = 1'b1;
            sel_pc   = ferr_pc_r;
         end
         default: begin
            sel_code = CODE_RESET;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // acknowledge towards the core
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         take_r <= 1'b0;
      end else begin
         take_r <= take_go;
      end
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         exc_code_o   <= RST_WORD;
         exc_offset_o <= RST_OFFS;
         exc_group_o  <= RST_GRP;
      end else if (take_go) begin
         exc_code_o   <= sel_code;
         exc_offset_o <= sel_offs;
         exc_group_o  <= sel_grp;
      end
   end

   // only high-level entries load the cause and pc save registers
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         high_level_cause_reg_o <= RST_WORD;
         high_level_pc_save_o   <= RST_WORD;
      end else if (take_go && sel_hi) begin
         high_level_cause_reg_o <= sel_code;
         high_level_pc_save_o   <= sel_pc;
      end
   end

   assign exc_take_o = take_r;

   // ---------------------------------------------------------------
   // fetch error handler tracking
   // ---------------------------------------------------------------
   // no return path out of the handler is assumed; exit only clears the
   // busy mark so protection faults can be taken again
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (take_go && win_idx == SRC_FERR) begin
               state_nxt = ST_FERR;
            end
         end
         ST_FERR: begin
            if (take_go && win_idx == SRC_RESET) begin
               state_nxt = ST_RUN;
            end else if (handler_exit_i && !(take_go && win_idx == SRC_FERR)) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign ferr_busy_o = (state_r == ST_FERR);

   // ---------------------------------------------------------------
   // code flash status and correction notice
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ded_flag_r <= 1'b0;
      end else if (fif.ded_flash || flash_data_ded_i) begin
         ded_flag_r <= 1'b1;
      end else if (ded_clear_i) begin
         ded_flag_r <= 1'b0;
      end
   end

   assign double_error_flag_o = ded_flag_r;

   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fetch_fixed_o <= 1'b0;
      end else begin
         fetch_fixed_o <= fif.single_fix;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   prio_order_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      take_go |-> !hi_elig)
      else $error("lower group served before a higher one");

   reset_first_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      pend[SRC_RESET] && !take_r |=> exc_take_o && exc_group_o == GRP_P1 && exc_offset_o == OFFS_RESET)
      else $error("reset request not served first");

   nmi_group_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      exc_take_o && exc_code_o == CODE_NMI |-> exc_group_o == GRP_P2)
      else $error("nmi in wrong group");

   int_cond_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      exc_take_o && exc_group_o == GRP_P4 |-> $past(lo_accept_i))
      else $error("interrupt taken without acceptance");

   ferr_code_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      take_go && win_idx == SRC_FERR |=> exc_code_o == CODE_FERR && high_level_cause_reg_o == CODE_FERR)
      else $error("fetch error cause code wrong");

   ferr_offset_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      take_go && win_idx == SRC_FERR |=> exc_take_o && exc_offset_o == OFFS_FERR && exc_group_o == GRP_P7)
      else $error("fetch error offset or group wrong");

   ferr_uncond_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      fif.ferr_event && !hi_accept_i |-> ##[1:16] (exc_take_o && exc_code_o == CODE_FERR)
         or ##[1:16] (pend[SRC_RESET] || pend[SRC_NMI] || pend[SRC_SYS_ERR] || pend[SRC_DATAP]))
      else $error("fetch error held back by acceptance");

   ferr_pc_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      take_go && win_idx == SRC_FERR |=> high_level_pc_save_o == $past(ferr_pc_r))
      else $error("saved pc not the failing fetch");

   ferr_restart_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      state_r == ST_FERR && pend[SRC_FERR] && !take_r && !(|pend[SRC_DATAP:SRC_RESET])
         |=> exc_take_o && exc_code_o == CODE_FERR)
      else $error("fetch error in handler not restarted");

   nmi_in_ferr_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      state_r == ST_FERR && pend[SRC_NMI] && !take_r && !pend[SRC_RESET]
         |=> exc_take_o && exc_group_o == GRP_P2)
      else $error("nmi blocked during fetch error handling");

   ded_flag_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      fif.ded_flash |=> double_error_flag_o)
      else $error("double error flag not set");

   ded_hold_a : assert property (@(posedge clock_i) disable iff (!resetn_i)
      double_error_flag_o && !ded_clear_i |=> double_error_flag_o)
      else $error("double error flag dropped uncleared");

endmodule : exc_arbiter

/* dv/core_model.sv */
module core_model (
   input  wire logic        clock_i,
   input  wire logic        resetn_i,
   input  wire logic        exc_take_i,
   input  wire logic [15:0] exc_offset_i,
   input  wire logic        ferr_busy_i,
   input  wire logic        lo_open_i,
   input  wire logic        hi_open_i,
   input  wire logic        auto_exit_i,
   output logic             lo_accept_o,
   output logic             hi_accept_o,
   output logic             handler_exit_o,
   output logic [31:0]      core_pc_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] wait_r;

   // ---------------------------------------------------------------
   // core side of exception entry
   // ---------------------------------------------------------------
   assign lo_accept_o = lo_open_i;
   assign hi_accept_o = hi_open_i;

   // flow is left for the handler base on every take
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         core_pc_o <= 32'h0000_1000;
      end else if (exc_take_i) begin
         core_pc_o <= {16'h0000, exc_offset_i};
      end else begin
         core_pc_o <= core_pc_o + 32'h0000_0004;
      end
   end

   // recovery program never returns; it ends with one exit pulse
   always_ff @(posedge clock_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wait_r <= 3'h0;
      end else if (!ferr_busy_i || !auto_exit_i) begin
         wait_r <= 3'h0;
      end else if (wait_r != 3'h5) begin
         wait_r <= wait_r + 3'h1;
      end
   end

   assign handler_exit_o = (wait_r == 3'h4);
endmodule : core_model

/* dv/exception_priority_fetch_error_test.sv */
module exception_priority_fetch_error_test import exc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] SYS_CODE = 32'h0000_0231;
   localparam logic [31:0] INT_CODE = 32'h0000_1010;
   localparam logic [15:0] INT_OFFS = 16'h0100;

   logic        clock_i, resetn_i, rst_req, nmi, serr, int_req, exec_f, data_f;
   logic        fv, fu, fd, fs, ff, fdd, dclr, lo_open, hi_open, auto_exit;
   logic [31:0] fpc, code, cause, pcs, cpc;
   logic [15:0] offs;
   logic [2:0]  grp;
   logic        take, flag, busy, fixed, lo_acc, hi_acc, hexit;
   int          err_count = 0;
   int          cmp_count = 0;

   exc_arbiter dut (.clock_i(clock_i), .resetn_i(resetn_i), .reset_req_i(rst_req),
      .fe_nonmaskable_irq_i(nmi), .system_error_exc_i(serr), .sys_err_code_i(SYS_CODE),
      .int_req_i(int_req), .int_code_i(INT_CODE), .int_offset_i(INT_OFFS),
      .exec_protect_exc_i(exec_f), .data_protect_exc_i(data_f), .fetch_valid_i(fv),
      .fetch_undef_i(fu), .fetch_ded_i(fd), .fetch_sec_i(fs), .fetch_flash_i(ff),
      .fetch_pc_i(fpc), .flash_data_ded_i(fdd), .ded_clear_i(dclr), .core_pc_i(cpc),
      .lo_accept_i(lo_acc), .hi_accept_i(hi_acc), .handler_exit_i(hexit),
      .exc_take_o(take), .exc_code_o(code), .exc_offset_o(offs), .exc_group_o(grp),
      .high_level_cause_reg_o(cause), .high_level_pc_save_o(pcs),
      .double_error_flag_o(flag), .ferr_busy_o(busy), .fetch_fixed_o(fixed));

   core_model core (.clock_i(clock_i), .resetn_i(resetn_i), .exc_take_i(take),
      .exc_offset_i(offs), .ferr_busy_i(busy), .lo_open_i(lo_open), .hi_open_i(hi_open),
      .auto_exit_i(auto_exit), .lo_accept_o(lo_acc), .hi_accept_o(hi_acc),
      .handler_exit_o(hexit), .core_pc_o(cpc));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // waits a bounded span for the one-cycle take pulse
   task automatic expect_exc(input int n, input logic [2:0] g, input logic [31:0] c,
                             input logic [15:0] o);
      for (int i = 0; i < n; i++) begin
         @(negedge clock_i);
         if (take === 1'b1) break;
      end
      chk({31'h0, take}, 32'h1, "take missing");
      chk({29'h0, grp}, {29'h0, g}, "group");
      chk(code, c, "code");
      chk({16'h0, offs}, {16'h0, o}, "offset");
   endtask : expect_exc

   task automatic no_take(input int n);
      int seen;
      seen = 0;
      repeat (n) begin
         @(negedge clock_i);
         if (take !== 1'b0) seen++;
      end
      chk(32'(seen), 32'h0, "unexpected take");
   endtask : no_take

   // one cycle of each selected source: reset, nmi, sys err, int, exec, data
   task automatic pulse_src(input logic [5:0] m);
      @(negedge clock_i);
      {data_f, exec_f, int_req, serr, nmi, rst_req} = m;
      @(negedge clock_i);
      {data_f, exec_f, int_req, serr, nmi, rst_req} = 6'h00;
   endtask : pulse_src

   task automatic fetch(input logic u, input logic d, input logic s, input logic f,
                        input logic [31:0] a);
      @(negedge clock_i);
      {fv, fu, fd, fs, ff, fpc} = {1'b1, u, d, s, f, a};
      @(negedge clock_i);
      {fv, fu, fd, fs} = 4'h0;
   endtask : fetch

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_flash_ded;
      {lo_open, hi_open} = 2'b00;
      fetch(1'b0, 1'b1, 1'b0, 1'b1, 32'h0000_2468);
      expect_exc(5, GRP_FERR, CODE_FERR, OFFS_FERR);
      chk(cause, CODE_FERR, "cause");
      chk(pcs, 32'h0000_2468, "pc save");
      chk({31'h0, flag}, 32'h1, "flag set");
      chk({31'h0, busy}, 32'h1, "busy in handler");
      {lo_open, hi_open} = 2'b11;
      repeat (12) @(negedge clock_i);
      chk({31'h0, flag}, 32'h1, "flag sticky");
      chk({31'h0, busy}, 32'h0, "busy after exit");
      dclr = 1'b1;
      @(negedge clock_i);
      dclr = 1'b0;
      chk({31'h0, flag}, 32'h0, "flag clear");
   endtask : t_flash_ded

   task automatic t_ram_undef;
      for (int k = 0; k < 2; k++) begin
         fetch(k[0], !k[0], 1'b0, 1'b0, 32'h0000_3300 + 32'(k));
         expect_exc(5, GRP_FERR, CODE_FERR, OFFS_FERR);
         chk(pcs, 32'h0000_3300 + 32'(k), "pc save");
         chk({31'h0, flag}, 32'h0, "no flag");
         repeat (12) @(negedge clock_i);
      end
   endtask : t_ram_undef

   task automatic t_single;
      int seen;
      fetch(1'b0, 1'b0, 1'b1, 1'b1, 32'h0000_4000);
      seen = (fixed === 1'b1) ? 1 : 0;
      repeat (3) begin
         @(negedge clock_i);
         if (fixed === 1'b1) seen = 1;
      end
      chk(32'(seen), 32'h1, "fixed pulse");
      no_take(8);
      fdd = 1'b1;
      @(negedge clock_i);
      fdd = 1'b0;
      chk({31'h0, flag}, 32'h1, "data ded flag");
      dclr = 1'b1;
      @(negedge clock_i);
      dclr = 1'b0;
   endtask : t_single

   task automatic t_priority;
      logic [2:0]  g[6] = '{GRP_P2, GRP_P3, GRP_P4, GRP_P5, GRP_P7, GRP_FERR};
      logic [31:0] c[6] = '{CODE_NMI, SYS_CODE, INT_CODE, CODE_EXECP, CODE_DATAP, CODE_FERR};
      logic [15:0] o[6] = '{OFFS_NMI, OFFS_SYS_ERR, INT_OFFS, OFFS_EXECP, OFFS_DATAP, OFFS_FERR};
      pulse_src(6'h01);
      expect_exc(4, GRP_P1, CODE_RESET, OFFS_RESET);
      // all raised in one cycle so no take slips by unwatched; fetch error pends a cycle later
      @(negedge clock_i);
      {data_f, exec_f, int_req, serr, nmi, rst_req} = 6'h3E;
      {fv, fu, fd, fs, ff, fpc} = {5'b10100, 32'h0000_5000};
      @(negedge clock_i);
      {data_f, exec_f, int_req, serr, nmi, rst_req} = 6'h00;
      {fv, fd} = 2'b00;
      for (int i = 0; i < 6; i++) expect_exc(6, g[i], c[i], o[i]);
      repeat (12) @(negedge clock_i);
   endtask : t_priority

   task automatic t_pending;
      lo_open = 1'b0;
      pulse_src(6'h08);
      no_take(10);
      lo_open = 1'b1;
      expect_exc(4, GRP_P4, INT_CODE, INT_OFFS);
   endtask : t_pending

   task automatic t_nested;
      auto_exit = 1'b0;
      fetch(1'b0, 1'b1, 1'b0, 1'b0, 32'h0000_6000);
      expect_exc(5, GRP_FERR, CODE_FERR, OFFS_FERR);
      pulse_src(6'h10);
      no_take(8);
      fetch(1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_6100);
      expect_exc(5, GRP_FERR, CODE_FERR, OFFS_FERR);
      chk(pcs, 32'h0000_6100, "second pc save");
      pulse_src(6'h02);
      expect_exc(4, GRP_P2, CODE_NMI, OFFS_NMI);
      auto_exit = 1'b1;
      expect_exc(14, GRP_P5, CODE_EXECP, OFFS_EXECP);
   endtask : t_nested

   // ---------------------------------------------------------------
   // clock, reset, sequence, watchdog
   // ---------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #4 clock_i = ~clock_i;
   end

   initial begin
      {rst_req, nmi, serr, int_req, exec_f, data_f} = 6'h00;
      {fv, fu, fd, fs, ff, fdd, dclr} = 7'h00;
      {lo_open, hi_open, auto_exit} = 3'b111;
      fpc = 32'h0000_0000;
      resetn_i = 1'b0;
      repeat (5) @(negedge clock_i);
      resetn_i = 1'b1;
      @(negedge clock_i);
      t_flash_ded();
      t_ram_undef();
      t_single();
      t_priority();
      t_pending();
      t_nested();
      stop_test();
   end

   initial begin
      #(8 * 5000);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end
endmodule : exception_priority_fetch_error_test
